// ### cpwm_pkg.sv
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
package cpwm_pkg;
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_DUTY_HI   = 5'h04;
    localparam logic [4:0]  OFS_COMPARE   = 5'h08;
    localparam logic [4:0]  OFS_CAPTURE   = 5'h0C;
    localparam logic [4:0]  OFS_STATUS    = 5'h10;
    localparam logic [4:0]  OFS_TSEL      = 5'h14;
    localparam logic [4:0]  OFS_DEADBAND  = 5'h18;
    localparam logic [4:0]  OFS_STEER     = 5'h1C;
    localparam logic [15:0] CTRL_MASK_STD = 16'h003F;
    localparam logic [15:0] CTRL_MASK_ENH = 16'h00FF;
    localparam logic [3:0]  STEER_RST     = 4'h1;
    localparam logic [3:0]  PRE4_LAST     = 4'h3;
    localparam logic [3:0]  PRE16_LAST    = 4'hF;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [3:0]  M_OFF   = 4'h0, M_TOGGLE = 4'h2, M_CAP_FALL = 4'h4, M_CAP_RISE = 4'h5;
    localparam logic [3:0]  M_CAP4  = 4'h6, M_CAP16  = 4'h7, M_SET_HI   = 4'h8, M_SET_LO   = 4'h9;
    localparam logic [3:0]  M_SOFT  = 4'hA, M_SPECIAL = 4'hB, M_PWM     = 4'hC;
    localparam logic [1:0]  CFG_SINGLE = 2'h0, CFG_FWD = 2'h1, CFG_HALF = 2'h2, CFG_REV = 2'h3;

    typedef struct packed {
        logic [15:0] cc_count;     // capture_compare_timer value
        logic [7:0]  p1_count;     // first_period_timer count
        logic        p1_match;     // first period timer wraps at period
        logic [7:0]  p2_count;     // second_period_timer count
        logic        p2_match;     // second period timer wraps at period
        logic [1:0]  qphase;       // quarter-cycle phase or prescaler bits
        logic        instr_tick;   // one pulse every second clock (qphase[0])
    } cpwm_timers_t;

    typedef struct packed {
        logic [3:0] out;           // output_d..output_a level
        logic [3:0] oe;            // high while the unit owns the pin
    } cpwm_pins_t;

    typedef struct packed {
        logic        awready, wready, arready, aw_got, w_got, bvalid, rvalid;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic [15:0] ctrl, compare, capture;
        logic [7:0]  duty_hi;
        logic        flag, tsel, match_prev, cap_prev, cmp_out, pwm, tmr_rst;
        logic [6:0]  db_count, db_cnt;
        logic [3:0]  steer, pre_cnt;
        logic [9:0]  duty_lat;
        cpwm_pins_t  pins;
    } cpwm_state_t;
endpackage : cpwm_pkg

// ### cpwm_unit.sv
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module cpwm_unit #(
    parameter bit ENHANCED = 1'b1                    // 1: enhanced unit, 0: standard unit
) (
    input  wire logic                      aclk,     // 250 MHz clock
    input  wire logic                      aresetn,  // synchronous reset, low
    input  wire logic [cpwm_pkg::ADDR_W-1:0] awaddr, // write address
    input  wire logic                      awvalid,  // write address valid
    output logic                           awready,  // write address ready
    input  wire logic [31:0]               wdata,    // write data
    input  wire logic [3:0]                wstrb,    // write byte lanes
    input  wire logic                      wvalid,   // write data valid
    output logic                           wready,   // write data ready
    output logic [1:0]                     bresp,    // write response
    output logic                           bvalid,   // write response valid
    input  wire logic                      bready,   // write response ready
    input  wire logic [cpwm_pkg::ADDR_W-1:0] araddr, // read address
    input  wire logic                      arvalid,  // read address valid
    output logic                           arready,  // read address ready
    output logic [31:0]                    rdata,    // read data
    output logic [1:0]                     rresp,    // read response
    output logic                           rvalid,   // read data valid
    input  wire logic                      rready,   // read data ready
    input  wire cpwm_pkg::cpwm_timers_t    tmr,      // timer counts and wraps
    input  wire logic                      cap_in,   // capture pin level
    output cpwm_pkg::cpwm_pins_t           pins,     // outputs a-d and enables
    output logic                           tmr_rst,  // special event: timer reset
    output logic                           unit_interrupt_flag // sticky event flag
);
    import cpwm_pkg::*;

    cpwm_state_t r_reg, r_next;

    localparam logic [15:0] CTRL_MASK = ENHANCED ? CTRL_MASK_ENH : CTRL_MASK_STD;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                v[8*i +: 8] = d[8*i +: 8];
        return v;
    endfunction : wmerge

    function automatic logic drive(input logic act, input logic lvl);
        return act ? lvl : ~lvl;
    endfunction : drive

    //------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------
    logic [3:0]  mode;
    logic [1:0]  cfg;
    logic        is_pwm, is_cmp, cap_mode, hit, cap_rise, cap_fall, period_wrap;
    logic [9:0]  tbase;

    assign mode        = r_reg.ctrl[3:0];
    assign cfg         = r_reg.ctrl[7:6];
    assign is_pwm      = ENHANCED ? (mode[3:2] == 2'h3) : (mode == M_PWM);
    assign is_cmp      = (mode == M_TOGGLE) || (mode[3:2] == 2'h2);
    assign cap_mode    = (mode[3:2] == 2'h1);
    assign hit         = (tmr.cc_count == r_reg.compare) && !r_reg.match_prev;
    assign cap_rise    = cap_in && !r_reg.cap_prev;
    assign cap_fall    = !cap_in && r_reg.cap_prev;
    assign period_wrap = r_reg.tsel ? tmr.p2_match : tmr.p1_match;
    assign tbase       = r_reg.tsel ? {tmr.p2_count, tmr.qphase} : {tmr.p1_count, tmr.qphase};

    always_comb
    begin
        logic        wr_go, cap_ev, flag_set, flag_clr, lv_ac, lv_bd;
        logic [31:0] wv;
        wr_go    = 1'b0;
        cap_ev   = 1'b0;
        flag_set = 1'b0;
        flag_clr = 1'b0;
        lv_ac    = 1'b0;
        lv_bd    = 1'b0;
        wv       = '0;
        r_next   = r_reg;
        r_next.tmr_rst = 1'b0;

        //------------------------------------------------------------
        // AXI4-Lite write side
        //------------------------------------------------------------
        if (awvalid && r_reg.awready)
        begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = awaddr;
        end
        if (wvalid && r_reg.wready)
        begin
            r_next.w_got = 1'b1;
            r_next.wdata = wdata;
            r_next.wstrb = wstrb;
        end
        if (r_reg.bvalid && bready)
            r_next.bvalid = 1'b0;
        wr_go = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
        if (wr_go)
        begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            case (r_reg.awaddr)
                OFS_CTRL:
                begin
                    wv = wmerge({16'h0000, r_reg.ctrl}, r_reg.wdata, r_reg.wstrb);
                    r_next.ctrl = wv[15:0] & CTRL_MASK;
                    // entering a compare mode sets the pin to its start level
                    if (r_next.ctrl[3:0] != mode)
                        r_next.cmp_out = (r_next.ctrl[3:0] == M_SET_LO);
                end
                OFS_DUTY_HI:
                begin
                    wv = wmerge({24'h000000, r_reg.duty_hi}, r_reg.wdata, r_reg.wstrb);
                    r_next.duty_hi = wv[7:0];
                end
                OFS_COMPARE:
                begin
                    wv = wmerge({16'h0000, r_reg.compare}, r_reg.wdata, r_reg.wstrb);
                    r_next.compare = wv[15:0];
                end
                OFS_STATUS:     flag_clr = r_reg.wstrb[0] && r_reg.wdata[0];
                OFS_TSEL:
                begin
                    wv = wmerge({31'h00000000, r_reg.tsel}, r_reg.wdata, r_reg.wstrb);
                    r_next.tsel = wv[0];
                end
                OFS_DEADBAND:
                begin
                    wv = wmerge({25'h0000000, r_reg.db_count}, r_reg.wdata, r_reg.wstrb);
                    r_next.db_count = wv[6:0];
                end
                OFS_STEER:
                begin
                    wv = wmerge({28'h0000000, r_reg.steer}, r_reg.wdata, r_reg.wstrb);
                    r_next.steer = wv[3:0];
                end
                OFS_CAPTURE:    r_next.bresp = RESP_OKAY;                   // read-only, write dropped
                default:        r_next.bresp = RESP_SLVERR;
            endcase
        end
        r_next.awready = !r_next.aw_got && !r_next.bvalid;
        r_next.wready  = !r_next.w_got && !r_next.bvalid;

        //------------------------------------------------------------
        // capture and compare engine
        //------------------------------------------------------------
        r_next.cap_prev   = cap_in;
        r_next.match_prev = (tmr.cc_count == r_reg.compare);
        if (cap_mode)
        begin
            case (mode)
                M_CAP_FALL: cap_ev = cap_fall;
                M_CAP_RISE: cap_ev = cap_rise;
                M_CAP4, M_CAP16:
                    if (cap_rise)
                    begin
                        cap_ev = (r_reg.pre_cnt == ((mode == M_CAP4) ? PRE4_LAST : PRE16_LAST));
                        r_next.pre_cnt = cap_ev ? 4'h0 : r_reg.pre_cnt + 4'h1;
                    end
                default:    cap_ev = 1'b0;
            endcase
            if (cap_ev)
            begin
                r_next.capture = tmr.cc_count;
                flag_set = 1'b1;
            end
        end
        if (is_cmp && hit)
        begin
            flag_set = 1'b1;
            case (mode)
                M_SET_HI:   r_next.cmp_out = 1'b1;
                M_SET_LO:   r_next.cmp_out = 1'b0;
                M_TOGGLE:   r_next.cmp_out = ~r_reg.cmp_out;
                M_SPECIAL:  r_next.tmr_rst = 1'b1;
                default:    r_next.cmp_out = r_reg.cmp_out;
            endcase
        end

        //------------------------------------------------------------
        // pwm and dead band
        //------------------------------------------------------------
        if (is_pwm)
        begin
            if (period_wrap)
            begin
                r_next.pwm      = 1'b1;
                r_next.duty_lat = {r_reg.duty_hi, r_reg.ctrl[5:4]};
            end
            else if (tbase == r_reg.duty_lat)
                r_next.pwm = 1'b0;
            // one counter serves both edges since they alternate
            if (r_next.pwm != r_reg.pwm)
                r_next.db_cnt = r_reg.db_count;
            else if (tmr.instr_tick && r_reg.db_cnt != 7'h00)
                r_next.db_cnt = r_reg.db_cnt - 7'h01;
        end
        if (mode == M_OFF)
        begin
            // a write that leaves the off state must keep its compare start level
            r_next.cmp_out = (r_next.ctrl[3:0] == M_SET_LO);
            r_next.pre_cnt = 4'h0;
            r_next.pwm     = 1'b0;
            r_next.db_cnt  = 7'h00;
        end
        r_next.flag = (r_reg.flag && !flag_clr) || flag_set;                 // set wins

        //------------------------------------------------------------
        // pin ownership
        //------------------------------------------------------------
        r_next.pins = '0;
        lv_ac = ~mode[1];
        lv_bd = ~mode[0];
        if (is_pwm && !ENHANCED)
        begin
            r_next.pins.out[0] = r_next.pwm;
            r_next.pins.oe[0]  = 1'b1;
        end
        else if (is_pwm)
        begin
            case (cfg)
                CFG_SINGLE:
                    for (int i = 0; i < 4; i++)
                    begin
                        r_next.pins.out[i] = drive(r_next.pwm, (i % 2 == 0) ? lv_ac : lv_bd);
                        r_next.pins.oe[i]  = r_reg.steer[i];
                    end
                CFG_FWD:
                begin
                    r_next.pins.out = {drive(r_next.pwm, lv_bd), drive(1'b0, lv_ac),
                                       drive(1'b0, lv_bd), drive(1'b1, lv_ac)};
                    r_next.pins.oe  = 4'hF;
                end
                CFG_HALF:
                begin
                    r_next.pins.out[0] = drive(r_next.pwm && r_next.db_cnt == 7'h00, lv_ac);
                    r_next.pins.out[1] = drive(!r_next.pwm && r_next.db_cnt == 7'h00, lv_bd);
                    r_next.pins.oe     = 4'h3;
                end
                default:
                begin
                    r_next.pins.out = {drive(1'b0, lv_bd), drive(1'b1, lv_ac),
                                       drive(r_next.pwm, lv_bd), drive(1'b0, lv_ac)};
                    r_next.pins.oe  = 4'hF;
                end
            endcase
        end
        else if (is_cmp && mode != M_SOFT && mode != M_SPECIAL)
        begin
            r_next.pins.out[0] = r_next.cmp_out;
            r_next.pins.oe[0]  = 1'b1;
        end

        //------------------------------------------------------------
        // AXI4-Lite read side
        //------------------------------------------------------------
        if (r_reg.rvalid && rready)
            r_next.rvalid = 1'b0;
        if (arvalid && r_reg.arready)
        begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            case (araddr)
                OFS_CTRL:     r_next.rdata = {16'h0000, r_reg.ctrl & CTRL_MASK};
                OFS_DUTY_HI:  r_next.rdata = {24'h000000, r_reg.duty_hi};
                OFS_COMPARE:  r_next.rdata = {16'h0000, r_reg.compare};
                OFS_CAPTURE:  r_next.rdata = {16'h0000, r_reg.capture};
                OFS_STATUS:   r_next.rdata = {29'h00000000, r_reg.pwm, r_reg.cmp_out, r_reg.flag};
                OFS_TSEL:     r_next.rdata = {31'h00000000, r_reg.tsel};
                OFS_DEADBAND: r_next.rdata = {25'h0000000, r_reg.db_count};
                OFS_STEER:    r_next.rdata = {28'h0000000, r_reg.steer};
                default:
                begin
                    r_next.rdata = 32'h00000000;
                    r_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        r_next.arready = !r_next.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg       <= '0;
            r_reg.steer <= STEER_RST;
        end
        else
            r_reg <= r_next;
    end

    assign awready             = r_reg.awready;
    assign wready              = r_reg.wready;
    assign bvalid              = r_reg.bvalid;
    assign bresp               = r_reg.bresp;
    assign arready             = r_reg.arready;
    assign rvalid              = r_reg.rvalid;
    assign rdata               = r_reg.rdata;
    assign rresp               = r_reg.rresp;
    assign pins                = r_reg.pins;
    assign tmr_rst             = r_reg.tmr_rst;
    assign unit_interrupt_flag = r_reg.flag;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence special_hit;
        (mode == M_SPECIAL) && hit;
    endsequence
    sequence rst_pulse;
        tmr_rst && unit_interrupt_flag ##1 !tmr_rst;
    endsequence

    special_event_a: assert property (special_hit |=> rst_pulse)
        else $error("special event did not pulse timer reset");
    disable_free_a: assert property ((mode == M_OFF) |=> (pins.oe == 4'h0) && !r_reg.pwm)
        else $error("disabled unit still drives pins");
    capture_copy_a: assert property ((mode == M_CAP_RISE) && cap_rise
                                     |=> (r_reg.capture == $past(tmr.cc_count)) && unit_interrupt_flag)
        else $error("capture value or flag wrong");
    set_high_a: assert property ((mode == M_SET_HI) && hit |=> pins.out[0] && pins.oe[0])
        else $error("pin not driven high on match");
    set_low_a: assert property ((mode == M_SET_LO) && hit |=> !pins.out[0] && pins.oe[0])
        else $error("pin not driven low on match");
    soft_only_a: assert property ((mode == M_SOFT) |=> !pins.oe[0])
        else $error("software-only mode drives the pin");
    toggle_pin_a: assert property ((mode == M_TOGGLE) && hit && $stable(mode)
                                   |=> pins.out[0] != $past(pins.out[0]))
        else $error("pin did not toggle on match");
    pwm_wrap_a: assert property (is_pwm && period_wrap && (mode != M_OFF) |=> r_reg.pwm)
        else $error("pwm not active after period wrap");
    ctrl_read_a: assert property (arvalid && arready && (araddr == OFS_CTRL)
                                  |=> rvalid && (rdata[31:8] == 24'h000000))
        else $error("unimplemented control bits read nonzero");
    fwd_bridge_a: assert property (ENHANCED && is_pwm && (cfg == CFG_FWD) && $stable(r_reg.ctrl)
                                   |=> (pins.oe == 4'hF) && (pins.out[0] == ~mode[1]))
        else $error("forward bridge output A not active");

    sequence half_edge;
        ENHANCED && is_pwm && (cfg == CFG_HALF) && (mode[1:0] == 2'h0)
            && (r_next.pwm != r_reg.pwm) && (r_reg.db_count != 7'h00);
    endsequence
    sequence pair_idle;
        pins.out[1:0] == 2'b00;
    endsequence

    dead_band_a: assert property (half_edge |=> pair_idle)
        else $error("dead band did not hold the half bridge inactive");
    half_pair_a: assert property (ENHANCED && is_pwm && (cfg == CFG_HALF) && (mode[1:0] == 2'h0)
                                  |=> (pins.oe == 4'h3) && !(pins.out[0] && pins.out[1]))
        else $error("half bridge outputs overlap or wrong pins owned");
    rev_bridge_a: assert property (ENHANCED && is_pwm && (cfg == CFG_REV)
                                   |=> (pins.oe == 4'hF) && (pins.out[2] != $past(mode[1])))
        else $error("reverse bridge output C not active");
    steer_oe_a: assert property (ENHANCED && is_pwm && (cfg == CFG_SINGLE)
                                 |=> (pins.oe == $past(r_reg.steer)))
        else $error("steering did not pick the owned outputs");
    port_pins_a: assert property (!is_pwm |=> (pins.oe[3:1] == 3'b000))
        else $error("outputs B to D owned outside pwm");
    duty_fall_a: assert property (is_pwm && !period_wrap && (tbase == r_reg.duty_lat) |=> !r_reg.pwm)
        else $error("pwm not inactive at duty match");
    duty_latch_a: assert property (is_pwm && period_wrap |=> (r_reg.duty_lat[9:2] == $past(r_reg.duty_hi))
                                   && (r_reg.duty_lat[1:0] == $past(r_reg.ctrl[5:4])))
        else $error("duty not latched from both duty fields");
    timer_pick_a: assert property (is_pwm && r_reg.tsel && tmr.p2_match |=> r_reg.pwm)
        else $error("second period timer did not start the pwm period");
    ctrl_mask_a: assert property ((r_reg.ctrl & ~CTRL_MASK) == 16'h0000)
        else $error("unimplemented control bits hold ones");
    event_only_a: assert property (tmr_rst |-> ($past(mode) == M_SPECIAL))
        else $error("timer reset outside special event mode");
    cap_fall_a: assert property ((mode == M_CAP_FALL) && cap_fall
                                 |=> (r_reg.capture == $past(tmr.cc_count)) && unit_interrupt_flag)
        else $error("falling edge capture missed");
endmodule : cpwm_unit

// ### cpwm_far.sv
`timescale 1ns/1ns
module cpwm_far (
    input  wire logic                   aclk,    // clock
    input  wire logic                   aresetn, // sync reset, low
    input  wire logic                   run,     // capture/compare timer advances
    input  wire logic                   cap_lvl, // edge level asked by bench
    input  wire logic                   tmr_rst, // special event from unit
    output cpwm_pkg::cpwm_timers_t      tmr,     // timer counts and wraps
    output logic                        cap_in   // capture pin level
);
    import cpwm_pkg::*;
    //--------------------------------------------------------
    // timers: cc counts 0..FF so matches come quickly
    //--------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        cap_in <= cap_lvl;
        if (!aresetn)
            tmr <= '0;
        else
        begin
            if (tmr_rst)
                tmr.cc_count <= 16'h0000;
            else if (run)
                tmr.cc_count <= {8'h00, tmr.cc_count[7:0] + 8'h01};
            tmr.qphase     <= tmr.qphase + 2'h1;
            tmr.instr_tick <= tmr.qphase[0];
            tmr.p1_match   <= (tmr.qphase == 2'h3) && (tmr.p1_count == 8'h3F);
            tmr.p2_match   <= (tmr.qphase == 2'h3) && (tmr.p2_count == 8'h7F);
            if (tmr.qphase == 2'h3)
            begin
                tmr.p1_count <= (tmr.p1_count == 8'h3F) ? 8'h00 : tmr.p1_count + 8'h01;
                tmr.p2_count <= (tmr.p2_count == 8'h7F) ? 8'h00 : tmr.p2_count + 8'h01;
            end
        end
    end
endmodule : cpwm_far

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    import cpwm_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, run = 1'b1, cap_lvl = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tmr_rst, unit_interrupt_flag, cap_in;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [3:0]        wstrb = 4'hF, mm;
    logic [1:0]        bresp, rresp;
    logic [15:0]       cmp, frz;
    logic [31:0]       q[$];
    cpwm_timers_t      tmr;
    cpwm_pins_t        pins;
    logic [3:0]        cm[5] = '{M_SET_HI, M_SET_LO, M_TOGGLE, M_SOFT, M_SPECIAL};
    logic [3:0]        capm[4] = '{M_CAP_FALL, M_CAP_RISE, M_CAP4, M_CAP16};
    int                capn[4] = '{1, 1, 4, 16};
    int                n_fail = 0, n_checks = 0, cyc = 0, t, c[4];
    bit                saw_rst;
    always #2 aclk = ~aclk;
    cpwm_unit #(.ENHANCED(1'b1)) i_cpwm_unit (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .tmr, .cap_in, .pins, .tmr_rst, .unit_interrupt_flag);
    cpwm_far i_cpwm_far (.aclk, .aresetn, .run, .cap_lvl, .tmr_rst, .tmr, .cap_in);
    task final_report();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [31:0] d);
        bit pa, pw, pb;
        {pa, pw, pb} = 3'b111;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (pa | pw | pb)
        begin
            @(posedge aclk);
            if (awready) pa = 1'b0;
            if (wready) pw = 1'b0;
            if (bvalid) pb = 1'b0;
            {awvalid, wvalid, bready} <= {pa, pw, pb};
        end
    endtask : wr
    // the monitor below pops the expectation when the answer appears
    task rd(input logic [4:0] a, input logic [31:0] e);
        bit pa, pb;
        {pa, pb} = 2'b11;
        q.push_back(e);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (pa | pb)
        begin
            @(posedge aclk);
            if (arready) pa = 1'b0;
            if (rvalid) pb = 1'b0;
            {arvalid, rready} <= {pa, pb};
        end
    endtask : rd
    task pulse();
        cap_lvl <= 1'b1;
        repeat (4) @(posedge aclk);
        cap_lvl <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : pulse
    task meas(input logic [31:0] e0, e1, e2, e3);
        c = '{default: 0};
        repeat (512)
        begin
            @(posedge aclk);
            for (int i = 0; i < 4; i++) if (pins.out[i] === 1'b1) c[i]++;
        end
        chk(c[0], e0);
        chk(c[1], e1);
        chk(c[2], e2);
        chk(c[3], e3);
    endtask : meas
    //--------------------------------------------------------
    // watcher: read answers, special events, hang limit
    //--------------------------------------------------------
    always @(posedge aclk)
    begin
        cyc++;
        if (tmr_rst === 1'b1) saw_rst = 1'b1;
        if (rvalid && rready) chk(rdata, q.pop_front());
        if (bvalid && bready) chk(bresp, RESP_OKAY);
        if (rvalid && rready) chk(rresp, RESP_OKAY);
        if (cyc == 60000)
        begin
            n_fail++;
            final_report();
        end
    end
    initial
    begin
        void'($urandom(32'hD333646C));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_STEER, {28'h0, STEER_RST});
        wr(OFS_CTRL, 32'hFFFF_FF30);
        rd(OFS_CTRL, 32'h0000_0030);
        for (int k = 0; k < 5; k++)
        begin
            run <= 1'b0;
            wr(OFS_CTRL, 32'h0);
            @(posedge aclk);
            chk(32'(pins.oe), 32'h0);
            cmp = {8'h00, tmr.cc_count[7:0] + 8'h20 + 8'($urandom_range(192))};
            wr(OFS_COMPARE, {16'h0, cmp});
            wr(OFS_STATUS, 32'h1);
            saw_rst = 1'b0;
            wr(OFS_CTRL, {28'h0, cm[k]});
            @(posedge aclk);
            if (k < 2) chk(pins.out[0], cm[k][0]);
            run <= 1'b1;
            t = 0;
            while (unit_interrupt_flag !== 1'b1 && t < 300)
            begin
                @(posedge aclk);
                t++;
            end
            repeat (2) @(posedge aclk);
            chk(unit_interrupt_flag, 1'b1);
            if (k < 3) chk(pins.out[0], 3'b101 >> k & 1);
            chk(pins.oe[0], k < 3);
            chk(saw_rst, k == 4);
        end
        for (int k = 0; k < 4; k++)
        begin
            run <= 1'b0;
            wr(OFS_CTRL, 32'h0);
            wr(OFS_STATUS, 32'h1);
            wr(OFS_CTRL, {28'h0, capm[k]});
            frz = tmr.cc_count;
            repeat (capn[k] - 1) pulse();
            chk(unit_interrupt_flag, 1'b0);
            pulse();
            chk(unit_interrupt_flag, 1'b1);
            rd(OFS_CAPTURE, {16'h0, frz});
        end
        run <= 1'b1;
        wr(OFS_DUTY_HI, 32'h20);
        wr(OFS_CTRL, 32'h6C);
        repeat (512) @(posedge aclk);
        chk(32'(pins.oe), 32'hF);
        meas(512, 0, 0, 260);
        for (int m = 12; m < 16; m++)
        begin
            mm = m[3:0];
            wr(OFS_CTRL, {24'h0, 4'hE, mm});
            repeat (512) @(posedge aclk);
            meas(mm[1] ? 512 : 0, mm[0] ? 252 : 260, mm[1] ? 0 : 512, mm[0] ? 512 : 0);
        end
        wr(OFS_TSEL, 32'h1);
        wr(OFS_CTRL, 32'h6C);
        repeat (1024) @(posedge aclk);
        meas(512, 0, 0, 130);
        t = $urandom_range(40, 1);
        wr(OFS_DEADBAND, t);
        wr(OFS_CTRL, 32'hAC);
        repeat (1024) @(posedge aclk);
        chk(32'(pins.oe), 32'h3);
        meas(130 - 2 * t, 382 - 2 * t, 0, 0);
        mm = 4'($urandom);
        wr(OFS_STEER, {28'h0, mm});
        wr(OFS_CTRL, 32'h2C);
        repeat (2) @(posedge aclk);
        chk(32'(pins.oe), {28'h0, mm});
        meas(130, 130, 130, 130);
        final_report();
    end
endmodule : testbench
